// [hw/spmc_pkg.sv]
// package: register map, mode weights and carrier structs for the serial port mode control
package spmc_pkg;

   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0]  SPMC_ADR_MODE0 = 8'h00;
   localparam logic [7:0]  SPMC_ADR_MODE1 = 8'h04;
   localparam logic [7:0]  SPMC_ADR_LOGIN = 8'h08;
   localparam logic [7:0]  SPMC_ADR_STAT  = 8'h0C;

   // ------------------------------------------------------------
   // mode word: each weight is a power of two, so its bit position
   // ------------------------------------------------------------
   localparam int          SPMC_MODE_W  = 16;
   localparam int          SPMC_B_QUIET = 0;   // weight 1
   localparam int          SPMC_B_COMP  = 1;   // weight 2
   localparam int          SPMC_B_GATE  = 2;   // weight 4
   localparam int          SPMC_B_HWFC  = 3;   // weight 8
   localparam int          SPMC_B_HESS  = 4;   // weight 16
   localparam int          SPMC_B_MDROP = 5;   // weight 32
   localparam int          SPMC_B_MODEM = 6;   // weight 64
   localparam int          SPMC_B_PFIX  = 7;   // weight 128
   localparam int          SPMC_B_XON   = 8;   // weight 256
   localparam int          SPMC_B_FIFO  = 9;   // weight 512
   localparam int          SPMC_B_RS485 = 10;  // weight 1024
   localparam int          SPMC_B_E71   = 11;  // weight 2048
   localparam int          SPMC_B_PRMPT = 12;  // weight 4096
   localparam int          SPMC_B_E81   = 13;  // weight 8192
   localparam logic [15:0] SPMC_MODE_MASK = 16'h3FFF;
   localparam logic [15:0] SPMC_MODE_RST  = 16'h0380;
   localparam logic [1:0]  SPMC_LOGIN_RST = 2'h0;
   localparam int          SPMC_RS485_PORT = 1;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic rx_v;       // character received
      logic cmd_v;      // complete command parsed
      logic cmd_help;   // that command is the help request
      logic addr_hit;   // command carried this unit's identifier
      logic fb_v;       // feedback message pending
      logic fb_req;     // feedback was asked for by the remote party
      logic cts;        // clear-to-send from the remote party
      logic rx_room;    // local receive side can take data
   } spmc_evt_t;

   typedef struct packed {
      logic echo;
      logic cmd_ok;
      logic fb_send;
      logic tx_allow;
      logic rts;
      logic modem_init;
      logic modem_lines;
      logic parity_en;
      logic data7;
      logic hessen;
      logic pfix;
      logic xon;
      logic fifo;
      logic rs485;
      logic mdrop;
      logic prompt;
   } spmc_ctl_t;

endpackage

// [hw/spmc_top.sv]
// module: per-port serial mode words with wishbone access and decoded port controls
//
// Functional notes
// [RULE1] each port holds a mode word equal to the sum of enabled weights, readable
// [RULE2] weight 1 suppresses unsolicited feedback; requested feedback still goes out
// [RULE3] weight 2 stops echo of received characters
// [RULE4] weight 4 gates the port: before login only the help command is taken
// [RULE5] weight 8 paces transmit with rts/cts; remote must drive its handshake
// [RULE6] weight 16 selects the hessen protocol instead of the native commands
// [RULE7] weight 32 enables multidrop; commands must carry this unit's identifier
// [RULE8] weight 64 sends a modem init after power-up and asserts modem lines
// [RULE9] weight 128 enables parity error correction for hessen installations
// [RULE10] weight 256 governs software xon/xoff flow control
// [RULE11] weight 512 governs use of the hardware fifo for throughput
// [RULE12] weight 1024 puts the second port in rs-485; it overrides multidrop
// [RULE13] default framing is no parity, 8 data bits, 1 stop bit
// [RULE14] weight 8192 selects even parity, 8 data bits, 1 stop bit
// [RULE15] weight 2048 selects even parity, 7 data bits, 1 stop bit
// [RULE16] weight 4096 enables the command prompt in terminal mode
// [RULE17] the two ports have independent mode words
// [RULE18] weights 128, 256 and 512 are on after reset
// [RULE19] both even parity weights set gives 7 data bit framing
`timescale 1ns/10ps
module spmc_top (
   input  wire  logic                          clk_i,
   input  wire  logic                          rst_i,
   input  wire  logic [7:0]                    adr_i,
   input  wire  logic [31:0]                   dat_i,
   output logic       [31:0]                   dat_o,
   input  wire  logic                          we_i,
   input  wire  logic [3:0]                    sel_i,
   input  wire  logic                          cyc_i,
   input  wire  logic                          stb_i,
   output logic                                ack_o,
   input  wire  spmc_pkg::spmc_evt_t [1:0]     evt_i,
   output spmc_pkg::spmc_ctl_t       [1:0]     ctl_o
);
   import spmc_pkg::*;

   // ------------------------------------------------------------
   // wishbone slave
   // ------------------------------------------------------------
   logic [15:0] mode_reg   [2];
   logic [15:0] mode_next  [2];
   logic [1:0]  login_reg;
   logic [1:0]  login_next;
   logic [1:0]  minit_done_reg;
   logic        ack_reg;
   logic        ack_next;
   logic [31:0] dat_reg;
   logic [31:0] dat_next;
   logic        req;
   logic        wr;

   // one wait state: ack rises the edge after the request is seen
   assign req = cyc_i & stb_i & ~ack_reg;
   assign wr  = req & we_i;

   always_comb begin
      ack_next   = req;
      dat_next   = 32'h0000_0000;
      login_next = login_reg;
      for (int p = 0; p < 2; p++) begin
         mode_next[p] = mode_reg[p];
      end
      if (req && !we_i) begin
         unique case (adr_i)
            SPMC_ADR_MODE0: dat_next = {16'h0000, mode_reg[0]};          // see [RULE1]
            SPMC_ADR_MODE1: dat_next = {16'h0000, mode_reg[1]};          // see [RULE17]
            SPMC_ADR_LOGIN: dat_next = {30'h0000_0000, login_reg};
            SPMC_ADR_STAT:  dat_next = {28'h000_0000, minit_done_reg, login_reg};
            default:        dat_next = 32'h0000_0000;
         endcase
      end
      if (wr) begin
         for (int p = 0; p < 2; p++) begin
            if (adr_i == (p == 0 ? SPMC_ADR_MODE0 : SPMC_ADR_MODE1)) begin
               if (sel_i[0]) mode_next[p][7:0]  = dat_i[7:0] & SPMC_MODE_MASK[7:0];
               if (sel_i[1]) mode_next[p][15:8] = dat_i[15:8] & SPMC_MODE_MASK[15:8];
            end
         end
         if (adr_i == SPMC_ADR_LOGIN && sel_i[0]) begin
            login_next = dat_i[1:0];
         end
      end
      // dropping the gate also drops any session, so re-arming needs a new login
      for (int p = 0; p < 2; p++) begin
         if (!mode_next[p][SPMC_B_GATE]) login_next[p] = 1'b0;                 // see [RULE4]
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_reg[0] <= SPMC_MODE_RST;                                         // see [RULE18]
         mode_reg[1] <= SPMC_MODE_RST;                                         // see [RULE18]
         login_reg   <= SPMC_LOGIN_RST;
         ack_reg     <= 1'b0;
         dat_reg     <= 32'h0000_0000;
      end else begin
         mode_reg[0] <= mode_next[0];
         mode_reg[1] <= mode_next[1];
         login_reg   <= login_next;
         ack_reg     <= ack_next;
         dat_reg     <= dat_next;
      end
   end

   assign ack_o = ack_reg;
   assign dat_o = dat_reg;

   // ------------------------------------------------------------
   // per-port decode and event gating
   // ------------------------------------------------------------
   spmc_ctl_t [1:0] ctl_reg;
   spmc_ctl_t [1:0] ctl_next;
   logic      [1:0] minit_done_next;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_port
         logic [15:0] m;
         logic        rs485_on;
         logic        mdrop_on;
         logic        open_gate;

         assign m         = mode_reg[g];
         assign rs485_on  = (g == SPMC_RS485_PORT) && m[SPMC_B_RS485];         // see [RULE12]
         assign mdrop_on  = m[SPMC_B_MDROP] && !rs485_on;                      // see [RULE12]
         assign open_gate = !m[SPMC_B_GATE] || login_reg[g];

         always_comb begin
            ctl_next[g]          = '0;
            minit_done_next[g]   = minit_done_reg[g];
            ctl_next[g].echo     = evt_i[g].rx_v && !m[SPMC_B_COMP];           // see [RULE3]
            ctl_next[g].cmd_ok   = evt_i[g].cmd_v
                                   && (open_gate || evt_i[g].cmd_help)         // see [RULE4]
                                   && (!mdrop_on || evt_i[g].addr_hit);        // see [RULE7]
            ctl_next[g].fb_send  = evt_i[g].fb_v
                                   && (!m[SPMC_B_QUIET] || evt_i[g].fb_req);   // see [RULE2]
            ctl_next[g].tx_allow = !m[SPMC_B_HWFC] || evt_i[g].cts;            // see [RULE5]
            ctl_next[g].rts      = !m[SPMC_B_HWFC] || evt_i[g].rx_room;        // see [RULE5]
            // init fires once after reset; a later enable does not replay it
            ctl_next[g].modem_init  = m[SPMC_B_MODEM] && !minit_done_reg[g];   // see [RULE8]
            if (m[SPMC_B_MODEM]) minit_done_next[g] = 1'b1;
            ctl_next[g].modem_lines = m[SPMC_B_MODEM];                         // see [RULE8]
            // e71 wins over e81 so framing is always one defined format
            ctl_next[g].parity_en = m[SPMC_B_E71] || m[SPMC_B_E81];            // see [RULE13] [RULE14]
            ctl_next[g].data7     = m[SPMC_B_E71];                             // see [RULE15] [RULE19]
            ctl_next[g].hessen    = m[SPMC_B_HESS];                            // see [RULE6]
            ctl_next[g].pfix      = m[SPMC_B_PFIX];                            // see [RULE9]
            ctl_next[g].xon       = m[SPMC_B_XON];                             // see [RULE10]
            ctl_next[g].fifo      = m[SPMC_B_FIFO];                            // see [RULE11]
            ctl_next[g].rs485     = rs485_on;                                  // see [RULE12]
            ctl_next[g].mdrop     = mdrop_on;                                  // see [RULE7]
            ctl_next[g].prompt    = m[SPMC_B_PRMPT];                           // see [RULE16]
         end

         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               ctl_reg[g]        <= '0;
               minit_done_reg[g] <= 1'b0;
            end else begin
               ctl_reg[g]        <= ctl_next[g];
               minit_done_reg[g] <= minit_done_next[g];
            end
         end
      end
   endgenerate

   assign ctl_o = ctl_reg;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence wr_mode0_s;
      cyc_i && stb_i && !ack_reg && we_i && adr_i == SPMC_ADR_MODE0 && sel_i == 4'hF;
   endsequence

   sequence rd_mode1_s;
      cyc_i && stb_i && !ack_reg && !we_i && adr_i == SPMC_ADR_MODE1;
   endsequence

   mode_sum_a: assert property (wr_mode0_s |=> mode_reg[0] == ($past(dat_i[15:0]) & SPMC_MODE_MASK)) // see [RULE1]
      else $error("mode word 0 did not take written weights");

   port_indep_a: assert property (wr_mode0_s |=> $stable(mode_reg[1]))     // see [RULE17]
      else $error("write to port 0 changed port 1");

   mode_read_a: assert property (rd_mode1_s |=> ack_o && dat_o[15:0] == mode_reg[1]) // see [RULE1]
      else $error("mode word 1 read back wrong");

   ack_pulse_a: assert property (ack_o |=> !ack_o)
      else $error("ack held more than one cycle");

   quiet_a: assert property (evt_i[0].fb_v && mode_reg[0][SPMC_B_QUIET] && !evt_i[0].fb_req
                             |=> !ctl_o[0].fb_send)                          // see [RULE2]
      else $error("unsolicited feedback sent in quiet mode");

   fb_req_a: assert property (evt_i[0].fb_v && evt_i[0].fb_req |=> ctl_o[0].fb_send) // see [RULE2]
      else $error("requested feedback was dropped");

   echo_a: assert property (evt_i[1].rx_v |=> ctl_o[1].echo == !$past(mode_reg[1][SPMC_B_COMP])) // see [RULE3]
      else $error("echo does not follow computer mode");

   gate_a: assert property (evt_i[0].cmd_v && !evt_i[0].cmd_help && mode_reg[0][SPMC_B_GATE]
                            && !login_reg[0] |=> !ctl_o[0].cmd_ok)           // see [RULE4]
      else $error("command taken before login");

   help_a: assert property (evt_i[0].cmd_v && evt_i[0].cmd_help && !mode_reg[0][SPMC_B_MDROP]
                            |=> ctl_o[0].cmd_ok)                             // see [RULE4]
      else $error("help request refused");

   hwfc_a: assert property (mode_reg[1][SPMC_B_HWFC] && !evt_i[1].cts |=> !ctl_o[1].tx_allow) // see [RULE5]
      else $error("transmit allowed without cts");

   rs485_a: assert property (mode_reg[1][SPMC_B_RS485] |=> ctl_o[1].rs485 && !ctl_o[1].mdrop) // see [RULE12]
      else $error("rs-485 did not override multidrop");

   port0_485_a: assert property (ctl_o[0].rs485 == 1'b0)                    // see [RULE12]
      else $error("first port entered rs-485");

   frame_a: assert property (mode_reg[0][SPMC_B_E71] && mode_reg[0][SPMC_B_E81]
                             |=> ctl_o[0].parity_en && ctl_o[0].data7)       // see [RULE19]
      else $error("dual parity weights not resolved to 7 bits");

   frame_dflt_a: assert property (!mode_reg[0][SPMC_B_E71] && !mode_reg[0][SPMC_B_E81]
                                  |=> !ctl_o[0].parity_en && !ctl_o[0].data7) // see [RULE13]
      else $error("default framing not 8n1");

   modem_once_a: assert property (ctl_o[0].modem_init |=> !ctl_o[0].modem_init) // see [RULE8]
      else $error("modem init repeated");

endmodule // spmc_top

// [dv/spmc_host_model.sv]
// host side model: per-port event strobes and handshake levels
`timescale 1ns/10ps
module spmc_host_model
   import spmc_pkg::*;
(
   input  wire logic                 clk_i,
   input  wire logic [1:0]           cts_i,
   input  wire logic [1:0]           room_i,
   output spmc_pkg::spmc_evt_t [1:0] evt_o
);
   logic [7:0] strobe [2];
   initial strobe = '{8'h00, 8'h00};
   // handshake levels stand between strobes so a stall is visible at any time
   assign evt_o[0] = strobe[0] | {6'h00, cts_i[0], room_i[0]};
   assign evt_o[1] = strobe[1] | {6'h00, cts_i[1], room_i[1]};
   // one-cycle strobe; the identifier bit is set only when addressed
   task automatic send(input int p, input logic [7:0] e);
      @(posedge clk_i);
      strobe[p] <= e;
      @(posedge clk_i);
      strobe[p] <= 8'h00;
   endtask
endmodule // spmc_host_model

// [dv/tb_top.sv]
// testbench: mode words, framing, gating and handshake decode
`timescale 1ns/10ps
module tb_top;
   import spmc_pkg::*;
   logic            clk_i = 1'b0;
   logic            rst_i = 1'b1;
   logic [7:0]      adr_i = 8'h00;
   logic [31:0]     dat_i = 32'h0;
   logic            we_i = 1'b0;
   logic            cyc_i = 1'b0;
   logic            stb_i = 1'b0;
   logic [3:0]      sel_i = 4'hF;
   logic [1:0]      cts_i = 2'h3;
   logic [1:0]      room_i = 2'h3;
   logic [31:0]     dat_o;
   logic            ack_o;
   logic [31:0]     rd;
   spmc_evt_t [1:0] evt;
   spmc_ctl_t [1:0] ctl_o;
   int              num_errors = 0;
   int              checks = 0;
   always #50 clk_i = ~clk_i;
   spmc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
      .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .evt_i(evt),
      .ctl_o(ctl_o));
   spmc_host_model HOST (.clk_i(clk_i), .cts_i(cts_i), .room_i(room_i), .evt_o(evt));
   task automatic end_sim();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      adr_i <= a;
      we_i <= w;
      dat_i <= d;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      // values read right after the edge are the ones that edge sampled
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n <= 20);
      if (n > 20) begin
         num_errors++;
         end_sim();
      end
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask
   task automatic wm(input logic [7:0] a, input logic [31:0] d);
      wb(a, 1'b1, d);
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
   endtask
   task automatic t_reset();
      wb(8'h00, 1'b0, 32'h0);
      chk("mode0", rd, 32'h0380);
      chk("pfix", ctl_o[0].pfix, 32'h1);
      chk("xon fifo", {ctl_o[1].xon, ctl_o[1].fifo}, 32'h3);
      chk("frame", {ctl_o[0].parity_en, ctl_o[0].data7}, 32'h0);
      wb(8'h10, 1'b1, 32'hFFFF);
      wb(8'h10, 1'b0, 32'h0);
      chk("unmapped", rd, 32'h0);
   endtask
   task automatic t_frame();
      logic [15:0] m [4];
      logic [1:0]  e [4];
      m = '{16'h0000, 16'h2000, 16'h0800, 16'h2800};
      e = '{2'h0, 2'h2, 2'h3, 2'h3};
      for (int i = 0; i < 4; i++) begin
         wm(8'h00, {16'h0, m[i]});
         chk("frame", {ctl_o[0].parity_en, ctl_o[0].data7}, {30'h0, e[i]});
      end
   endtask
   task automatic t_echo_quiet();
      wm(8'h00, 32'h0);
      HOST.send(0, 8'h88);
      @(negedge clk_i);
      chk("echo", {ctl_o[0].echo, ctl_o[0].fb_send}, 32'h3);
      wm(8'h00, 32'h3);
      HOST.send(0, 8'h88);
      @(negedge clk_i);
      chk("quiet", {ctl_o[0].echo, ctl_o[0].fb_send}, 32'h0);
      HOST.send(0, 8'h8C);
      @(negedge clk_i);
      chk("asked", {ctl_o[0].echo, ctl_o[0].fb_send}, 32'h1);
   endtask
   task automatic t_gate();
      wm(8'h00, 32'h4);
      HOST.send(0, 8'h40);
      @(negedge clk_i);
      chk("locked", ctl_o[0].cmd_ok, 32'h0);
      HOST.send(0, 8'h60);
      @(negedge clk_i);
      chk("help", ctl_o[0].cmd_ok, 32'h1);
      wm(8'h08, 32'h1);
      HOST.send(0, 8'h40);
      @(negedge clk_i);
      chk("login", ctl_o[0].cmd_ok, 32'h1);
   endtask
   task automatic t_sum_ports();
      wm(8'h00, 32'h23);
      wb(8'h00, 1'b0, 32'h0);
      chk("sum", rd, 32'h23);
      HOST.send(0, 8'h40);
      @(negedge clk_i);
      chk("no id", ctl_o[0].cmd_ok, 32'h0);
      HOST.send(0, 8'h50);
      @(negedge clk_i);
      chk("id", ctl_o[0].cmd_ok, 32'h1);
      @(posedge clk_i);
      cts_i <= 2'h1;
      room_i <= 2'h1;
      wm(8'h04, 32'h1478);
      chk("485", {ctl_o[1].rs485, ctl_o[1].mdrop}, 32'h2);
      chk("hwfc", {ctl_o[1].tx_allow, ctl_o[1].rts}, 32'h0);
      chk("mods", {ctl_o[1].modem_lines, ctl_o[1].hessen, ctl_o[1].prompt}, 32'h7);
      chk("mode0", {ctl_o[0].rs485, ctl_o[0].mdrop, ctl_o[0].tx_allow}, 32'h3);
      wb(8'h0C, 1'b0, 32'h0);
      chk("stat", rd, 32'h8);
      wb(8'h00, 1'b0, 32'h0);
      chk("mode0", rd, 32'h23);
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_frame();
      t_echo_quiet();
      t_gate();
      t_sum_ports();
      end_sim();
   end
endmodule // tb_top
